// >>> inc/lfs_pkg.sv
// Constants, types and helpers shared by the lamp flash sequencer and its timebase.
// Assumes a 50 MHz hclk and an AHB-Lite master that issues single whole-word transfers.
//
// Overview of operation
// - A pin select bit set to one turns that shared pin into a sink.
// - A channel sink is on only while its lamp enable bit is set.
// - Sink current is pulse-width modulated by a 5-bit duty; all ones is 100 percent.
// - Each channel has its own DC sink current between 2 mA and 20 mA.
// - Current code 0100b selects a 10 mA sink.
// - A sequencer enable bit starts that channel's flash sequencer while its lamp enable bit is also set.
// - Five slots, four numbered plus period, each 0 to 127 units of 64 ms.
// - In each slot whose lit bit is set the lamp is lit for its on-time between the two ramps.
// - Ramp-up and ramp-down step times, 0 to 31 of 8 ms, shared by channels.
// - Ramp enable at zero steps the current straight to its programmed value.
// - Ramp enable at one moves the current gradually up and down.
package lfs_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned RAMP_UNIT_MS = 8;
  localparam int unsigned SLOT_UNIT_MS = 64;
  localparam int unsigned RAMP_UNIT_CYC = CLK_HZ / 1000 * RAMP_UNIT_MS;
  localparam int unsigned RAMPS_PER_SLOT = SLOT_UNIT_MS / RAMP_UNIT_MS;

  localparam int NCH = 3;
  localparam int NSLOT = 5;

  // Register byte offsets
  localparam logic [7:0] OFF_PIN_SEL = 8'h00;
  localparam logic [7:0] OFF_LAMP_EN = 8'h04;
  localparam logic [7:0] OFF_RAMP = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_CH_BASE = 8'h10;
  localparam logic [7:0] OFF_CH_END = 8'h70;
  localparam int CH_SHIFT = 5;
  localparam logic [4:0] OFF_CUR = 5'h00;
  localparam logic [4:0] OFF_DUTY = 5'h04;
  localparam logic [4:0] OFF_CFG = 5'h08;
  localparam logic [4:0] OFF_SLOTS = 5'h0c;
  localparam logic [4:0] OFF_PERIOD = 5'h10;

  // Field positions
  localparam int EN_SEQ_LSB = 4;
  localparam int RAMP_DN_LSB = 8;
  localparam int CFG_RAMP_EN_BIT = 8;
  localparam int CFG_LIT_LSB = 16;
  localparam int SLOT_FIELD_STRIDE = 8;
  localparam int STAT_CH_STRIDE = 8;
  localparam int STAT_SLOT_LSB = 4;
  localparam int STAT_SINK_LSB = 24;

  // Reset values
  localparam logic [3:0] CUR_RST = 4'h0;
  localparam logic [4:0] DUTY_RST = 5'h1f;
  localparam logic [4:0] LIT_RST = 5'h1f;

  localparam logic [4:0] DUTY_FULL = 5'h1f;
  localparam logic [4:0] CUR_MA_MIN = 5'h02;
  localparam logic [4:0] CUR_MA_STEP = 5'h02;
  localparam logic [4:0] CUR_MA_MAX = 5'h14;

  typedef enum logic [2:0] {LFS_IDLE, LFS_UP, LFS_ON, LFS_DOWN, LFS_REST} lfs_state_t;

  // Sink current in mA: 2 mA plus 2 mA per code, held at 20 mA above code 9
  function automatic logic [4:0] lfs_cur_ma(input logic [3:0] code);
    logic [5:0] ma;
    ma = {1'b0, CUR_MA_MIN} + 6'({code, 1'b0});
    return (ma > {1'b0, CUR_MA_MAX}) ? CUR_MA_MAX : ma[4:0];
  endfunction

endpackage

// >>> inc/lfs_tick_if.sv
// Shared time base carried from the timebase module to the sequencer top.
// Assumes both ends run on hclk.
`timescale 1ns/1ps
`default_nettype none
interface lfs_tick_if;
  logic ramp_tick;
  logic slot_tick;
  logic [4:0] pwm_cnt;
  modport src (output ramp_tick, output slot_tick, output pwm_cnt);
  modport snk (input ramp_tick, input slot_tick, input pwm_cnt);
endinterface
`default_nettype wire

// >>> hw/lfs_timebase.sv
// Free-running 8 ms and 64 ms tick pulses and the 32-step PWM phase counter.
// Assumes hclk at the rate in the package; the 8 ms count is a parameter for short sims.
`timescale 1ns/1ps
`default_nettype none
module lfs_timebase
  import lfs_pkg::*;
#(
  parameter int unsigned RAMP_CYC = RAMP_UNIT_CYC
)
(
  input wire logic hclk,
  input wire logic hresetn,
  lfs_tick_if.src tb
);

  logic [31:0] div_q;
  logic [2:0] sub_q;
  logic wrap;

  assign wrap = (div_q == 32'(RAMP_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_q <= 32'h0;
      tb.ramp_tick <= 1'b0;
    end
    else
    begin
      div_q <= wrap ? 32'h0 : div_q + 32'h1;
      tb.ramp_tick <= wrap;
    end
  end

  // Slot tick is every eighth ramp tick, so both units stay phase aligned
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sub_q <= 3'h0;
      tb.slot_tick <= 1'b0;
    end
    else
    begin
      tb.slot_tick <= wrap && (sub_q == 3'(RAMPS_PER_SLOT - 1));
      if (wrap)
        sub_q <= sub_q + 3'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tb.pwm_cnt <= 5'h0;
    else
      tb.pwm_cnt <= tb.pwm_cnt + 5'h1;
  end

endmodule
`default_nettype wire

// >>> hw/lfs_top.sv
// Three-channel lamp sink driver with flash sequencer and AHB-Lite register slave.
// Assumes one AHB-Lite master with single word transfers; sink pins are analog-side levels.
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module lfs_top
  import lfs_pkg::*;
#(
  parameter int unsigned RAMP_CYC = RAMP_UNIT_CYC
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [2:0] lamp_pin_sel,
  output logic [2:0] lamp_sink_en,
  output logic [14:0] lamp_sink_ma
);

  lfs_tick_if tick_if ();

  lfs_timebase #(
    .RAMP_CYC(RAMP_CYC)
  ) u_timebase (
    .hclk(hclk),
    .hresetn(hresetn),
    .tb(tick_if)
  );

  // Bus slave state
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic addr_hit;
  logic [31:0] rd_val;

  // Software registers
  logic [2:0] pin_sel_q;
  logic [2:0] lamp_en_q;
  logic [2:0] seq_en_q;
  logic [4:0] ramp_up_q;
  logic [4:0] ramp_dn_q;
  logic [3:0] cur_q [NCH];
  logic [4:0] duty_q [NCH];
  logic [6:0] on_len_q [NCH];
  logic ramp_en_q [NCH];
  logic [4:0] lit_q [NCH];
  logic [6:0] slot_len_q [NCH][NSLOT];

  // Sequencer state visible to status reads
  logic [3:0] lvl_q [NCH];
  logic [2:0] slot_q [NCH];

  logic [1:0] wr_ch;
  logic [4:0] wr_off;

  assign addr_hit = hsel && htrans[1] && hready;
  assign wr_ch = 2'((addr_q - OFF_CH_BASE) >> CH_SHIFT);
  assign wr_off = 5'(addr_q - OFF_CH_BASE);

  // Writes complete with no wait; reads take one wait state so they see a prior write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
    end
    else
    begin
      wr_pend_q <= addr_hit && hwrite;
      rd_pend_q <= addr_hit && !hwrite;
      if (addr_hit)
        addr_q <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hff;
      hreadyout <= !(addr_hit && !hwrite);
      if (rd_pend_q)
        hrdata <= rd_val;
    end
  end

  always_comb
  begin
    logic [1:0] ch;
    logic [4:0] off;
    ch = 2'((addr_q - OFF_CH_BASE) >> CH_SHIFT);
    off = 5'(addr_q - OFF_CH_BASE);
    rd_val = 32'h0;
    if (addr_q == OFF_PIN_SEL)
      rd_val[2:0] = pin_sel_q;
    else if (addr_q == OFF_LAMP_EN)
    begin
      rd_val[2:0] = lamp_en_q;
      rd_val[EN_SEQ_LSB +: 3] = seq_en_q;
    end
    else if (addr_q == OFF_RAMP)
    begin
      rd_val[4:0] = ramp_up_q;
      rd_val[RAMP_DN_LSB +: 5] = ramp_dn_q;
    end
    else if (addr_q == OFF_STATUS)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        rd_val[i * STAT_CH_STRIDE +: 4] = lvl_q[i];
        rd_val[i * STAT_CH_STRIDE + STAT_SLOT_LSB +: 3] = slot_q[i];
      end
      rd_val[STAT_SINK_LSB +: 3] = lamp_sink_en;
    end
    else if (addr_q >= OFF_CH_BASE && addr_q < OFF_CH_END && addr_q[1:0] == 2'b00)
    begin
      unique case (off)
        OFF_CUR: rd_val[3:0] = cur_q[ch];
        OFF_DUTY: rd_val[4:0] = duty_q[ch];
        OFF_CFG:
        begin
          rd_val[6:0] = on_len_q[ch];
          rd_val[CFG_RAMP_EN_BIT] = ramp_en_q[ch];
          rd_val[CFG_LIT_LSB +: 5] = lit_q[ch];
        end
        OFF_SLOTS:
        begin
          for (int s = 0; s < NSLOT - 1; s++)
            rd_val[s * SLOT_FIELD_STRIDE +: 7] = slot_len_q[ch][s];
        end
        OFF_PERIOD: rd_val[6:0] = slot_len_q[ch][NSLOT - 1];
        default: rd_val = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_sel_q <= 3'h0;
      lamp_en_q <= 3'h0;
      seq_en_q <= 3'h0;
      ramp_up_q <= 5'h0;
      ramp_dn_q <= 5'h0;
      for (int i = 0; i < NCH; i++)
      begin
        cur_q[i] <= CUR_RST;
        duty_q[i] <= DUTY_RST;
        on_len_q[i] <= 7'h0;
        ramp_en_q[i] <= 1'b0;
        lit_q[i] <= LIT_RST;
        for (int s = 0; s < NSLOT; s++)
          slot_len_q[i][s] <= 7'h0;
      end
    end
    else if (wr_pend_q)
    begin
      if (addr_q == OFF_PIN_SEL)
        pin_sel_q <= hwdata[2:0];
      else if (addr_q == OFF_LAMP_EN)
      begin
        lamp_en_q <= hwdata[2:0];
        seq_en_q <= hwdata[EN_SEQ_LSB +: 3];
      end
      else if (addr_q == OFF_RAMP)
      begin
        ramp_up_q <= hwdata[4:0];
        ramp_dn_q <= hwdata[RAMP_DN_LSB +: 5];
      end
      else if (addr_q >= OFF_CH_BASE && addr_q < OFF_CH_END && addr_q[1:0] == 2'b00)
      begin
        unique case (wr_off)
          OFF_CUR: cur_q[wr_ch] <= hwdata[3:0];
          OFF_DUTY: duty_q[wr_ch] <= hwdata[4:0];
          OFF_CFG:
          begin
            on_len_q[wr_ch] <= hwdata[6:0];
            ramp_en_q[wr_ch] <= hwdata[CFG_RAMP_EN_BIT];
            lit_q[wr_ch] <= hwdata[CFG_LIT_LSB +: 5];
          end
          OFF_SLOTS:
          begin
            for (int s = 0; s < NSLOT - 1; s++)
              slot_len_q[wr_ch][s] <= hwdata[s * SLOT_FIELD_STRIDE +: 7];
          end
          OFF_PERIOD: slot_len_q[wr_ch][NSLOT - 1] <= hwdata[6:0];
          default:
          begin
          end
        endcase
      end
    end
  end

  // Flash sequencer, one copy per channel
  for (genvar g = 0; g < NCH; g++)
  begin : gen_ch
    lfs_state_t st_q;
    logic [6:0] scnt_q;
    logic [4:0] step_q;
    logic [6:0] ontm_q;
    logic run;
    logic [6:0] len;
    logic slot_end;
    logic [4:0] rate;
    logic step_due;
    logic on_done;
    logic [2:0] nxt_slot;
    logic nxt_lit;

    // each channel runs on its own enable
    assign run = seq_en_q[g] && lamp_en_q[g];
    assign len = slot_len_q[g][slot_q[g]];
    // slot length in 64 ms units
    assign slot_end = (len == 7'h0) ||
                      (tick_if.slot_tick && ({1'b0, scnt_q} + 8'h1 >= {1'b0, len}));
    // fixed slot order, wrapping after the period slot
    assign nxt_slot = (slot_q[g] == 3'(NSLOT - 1)) ? 3'h0 : slot_q[g] + 3'h1;
    assign nxt_lit = lit_q[g][nxt_slot];
    assign rate = (st_q == LFS_UP) ? ramp_up_q : ramp_dn_q;
    // one code step per elapsed ramp step time
    assign step_due = (rate == 5'h0) ||
                      (tick_if.ramp_tick && ({1'b0, step_q} + 6'h1 >= {1'b0, rate}));
    assign on_done = (on_len_q[g] == 7'h0) ||
                     (tick_if.ramp_tick && ({1'b0, ontm_q} + 8'h1 >= {1'b0, on_len_q[g]}));

    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        st_q <= LFS_IDLE;
        slot_q[g] <= 3'h0;
        scnt_q <= 7'h0;
        step_q <= 5'h0;
        ontm_q <= 7'h0;
        lvl_q[g] <= 4'h0;
      end
      // stop and drop the level to zero as soon as either enable drops
      else if (!run)
      begin
        st_q <= LFS_IDLE;
        slot_q[g] <= 3'h0;
        scnt_q <= 7'h0;
        step_q <= 5'h0;
        ontm_q <= 7'h0;
        lvl_q[g] <= 4'h0;
      end
      else if (st_q == LFS_IDLE)
      begin
        st_q <= lit_q[g][0] ? LFS_UP : LFS_REST;
        step_q <= 5'h0;
      end
      else if (slot_end)
      begin
        // Slot boundary wins over the lit phase; a too-short slot cuts the pulse off
        slot_q[g] <= nxt_slot;
        scnt_q <= 7'h0;
        step_q <= 5'h0;
        ontm_q <= 7'h0;
        lvl_q[g] <= 4'h0;
        st_q <= nxt_lit ? LFS_UP : LFS_REST;
      end
      else
      begin
        if (tick_if.slot_tick)
          scnt_q <= scnt_q + 7'h1;
        // ramp up, hold for on-time, ramp down within the slot
        unique case (st_q)
          LFS_UP:
          begin
            // no slope when ramping is off
            if (!ramp_en_q[g] || lvl_q[g] == cur_q[g])
            begin
              lvl_q[g] <= cur_q[g];
              st_q <= LFS_ON;
              ontm_q <= 7'h0;
            end
            // one code at a time toward the target
            else if (step_due)
            begin
              lvl_q[g] <= lvl_q[g] + 4'h1;
              step_q <= 5'h0;
            end
            else if (tick_if.ramp_tick)
              step_q <= step_q + 5'h1;
          end
          LFS_ON:
          begin
            lvl_q[g] <= cur_q[g];
            if (on_done)
            begin
              st_q <= LFS_DOWN;
              step_q <= 5'h0;
            end
            else if (tick_if.ramp_tick)
              ontm_q <= ontm_q + 7'h1;
          end
          LFS_DOWN:
          begin
            if (!ramp_en_q[g] || lvl_q[g] == 4'h0)
            begin
              lvl_q[g] <= 4'h0;
              st_q <= LFS_REST;
            end
            // one code at a time toward zero
            else if (step_due)
            begin
              lvl_q[g] <= lvl_q[g] - 4'h1;
              step_q <= 5'h0;
            end
            else if (tick_if.ramp_tick)
              step_q <= step_q + 5'h1;
          end
          LFS_REST: lvl_q[g] <= 4'h0;
          default: st_q <= LFS_IDLE;
        endcase
      end
    end
  end

  // Output stage: level source, PWM gate, current decode, all registered
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lamp_pin_sel <= 3'h0;
      lamp_sink_en <= 3'h0;
      lamp_sink_ma <= 15'h0;
    end
    else
    begin
      // shared pins follow their select bits
      lamp_pin_sel <= pin_sel_q;
      for (int i = 0; i < NCH; i++)
      begin
        logic [3:0] code;
        logic pwm_on;
        code = seq_en_q[i] ? lvl_q[i] : cur_q[i];
        // all-ones duty never gates the sink off
        pwm_on = (duty_q[i] == DUTY_FULL) || (tick_if.pwm_cnt < duty_q[i]);
        // sink needs the lamp enable and pin select
        lamp_sink_en[i] <= pin_sel_q[i] && lamp_en_q[i] && pwm_on &&
                           (!seq_en_q[i] || lvl_q[i] != 4'h0);
        // code 0100b decodes to 10 mA
        lamp_sink_ma[i * 5 +: 5] <= lfs_cur_ma(code);
      end
    end
  end

endmodule
`default_nettype wire

// >>> verif/lfs_lamp_model.sv
// Lamp model hanging on the three shared sink pins.
// Assumes the sink outputs are levels that settle between hclk edges.
`timescale 1ns/1ps
`default_nettype none
module lfs_lamp_model
(
  input wire logic [2:0] pin_sel,
  input wire logic [2:0] sink_en,
  input wire logic [14:0] sink_ma,
  output logic [2:0] lit,
  output logic [14:0] glow_ma
);
  // lamp conducts only through selected, enabled, gated sink
  assign lit = pin_sel & sink_en;
  // current flows only while the lamp is lit
  always_comb
    for (int i = 0; i < 3; i++)
      glow_ma[5*i+:5] = lit[i] ? sink_ma[5*i+:5] : 5'h00;
endmodule
`default_nettype wire

// >>> verif/lfs_checker.sv
// Concurrent checks on the sequencer's bus slave and sink outputs.
// Assumes hready is tied to hreadyout; bound into every lfs_top.
`timescale 1ns/1ps
`default_nettype none
module lfs_checker
  import lfs_pkg::*;
#(
  parameter int unsigned RAMP_CYC = RAMP_UNIT_CYC
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [2:0] lamp_pin_sel,
  input wire logic [2:0] lamp_sink_en,
  input wire logic [14:0] lamp_sink_ma
);
  logic wp_q;
  logic [7:0] wa_q;
  logic [2:0] en_q;
  logic [2:0] sel_q;
  wire logic take = hsel & htrans[1] & hready;
  // Shadow of what software wrote, so outputs can be tied to their cause
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wp_q <= 1'b0;
      wa_q <= 8'h00;
      en_q <= 3'h0;
      sel_q <= 3'h0;
    end
    else
    begin
      wp_q <= take & hwrite & (haddr[31:8] == 24'h0);
      wa_q <= haddr[7:0];
      if (wp_q && wa_q == OFF_LAMP_EN)
        en_q <= hwdata[2:0];
      if (wp_q && wa_q == OFF_PIN_SEL)
        sel_q <= hwdata[2:0];
    end
  function automatic logic ma_ok(input logic [4:0] m);
    return m >= 5'h02 && m <= 5'h14 && !m[0];
  endfunction
  a_sink_needs_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    (lamp_sink_en & ~lamp_pin_sel & ~$past(lamp_pin_sel)) == 3'h0) else $error("sink off pin");
  a_sel_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    wp_q && wa_q == OFF_PIN_SEL |-> ##[1:2] lamp_pin_sel == sel_q) else $error("pin select");
  a_enable_gates: assert property (@(posedge hclk) disable iff (!hresetn)
    (lamp_sink_en & ~en_q & ~$past(en_q) & ~$past(en_q, 2)) == 3'h0) else $error("sink on");
  a_ma_legal: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) |-> ma_ok(lamp_sink_ma[4:0]) && ma_ok(lamp_sink_ma[9:5])
    && ma_ok(lamp_sink_ma[14:10])) else $error("sink current out of range");
  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait");
  a_wait_cause: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(hreadyout) |-> $past(take && !hwrite)) else $error("wait without read");
  a_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(hrdata) |-> $rose(hreadyout)) else $error("read data moved");
  a_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && haddr[31:8] != 24'h0 |-> ##2 hrdata == 32'h0) else $error("unmapped");
  a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hresp == 1'b0) else $error("response not okay");
endmodule
bind lfs_top lfs_checker #(.RAMP_CYC(RAMP_CYC)) u_lfs_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .lamp_pin_sel(lamp_pin_sel), .lamp_sink_en(lamp_sink_en), .lamp_sink_ma(lamp_sink_ma));
`default_nettype wire

// >>> verif/tb_led_flash_sequencer.sv
// Self-checking bench for the lamp sequencer: bus, current, PWM, flash slots.
// Assumes a short ramp tick; the bench drives every input on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module tb_led_flash_sequencer
  import lfs_pkg::*;
;
  localparam int unsigned RC = 2;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp;
  logic [2:0] sel, sink_en, lit;
  logic [14:0] sink_ma, glow_ma;
  int miscompares = 0;
  int n_tests = 0;
  logic [31:0] ra [8] = '{32'h0, 32'h4, 32'h8, 32'h14, 32'h18, 32'h1c, 32'h54, 32'h100};
  logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, 32'h1f, 32'h001f0000, 32'h0, 32'h1f, 32'h0};
  lfs_top #(.RAMP_CYC(RC)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lamp_pin_sel(sel),
    .lamp_sink_en(sink_en), .lamp_sink_ma(sink_ma));
  lfs_lamp_model lamp (.pin_sel(sel), .sink_en(sink_en), .sink_ma(sink_ma), .lit(lit),
    .glow_ma(glow_ma));
  initial
    forever #10 hclk = ~hclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdy;
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 40);
    chk({31'h0, hreadyout}, 32'h1);
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  function automatic logic [31:0] ca(input int ch, input logic [4:0] off);
    return 32'(OFF_CH_BASE) + 32'(ch << CH_SHIFT) + 32'(off);
  endfunction
  function automatic logic [31:0] ema(input int c);
    return (c > 9) ? 32'h14 : 32'(2 + 2 * c);
  endfunction
  // Lit cycles in two PWM periods; all-ones duty keeps the sink on throughout
  function automatic logic [31:0] epwm(input int d);
    return (d >= 31) ? 32'h40 : 32'(2 * d);
  endfunction
  task automatic wrap_up;
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    wrap_up();
  end
  initial
  begin
    int ch, d, n, s, p, pm, seen, lo;
    void'($urandom(32'he72d));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b0, ra[i], 32'h0);
      chk(q, rv[i]);
    end
    bus(1'b1, 32'(OFF_PIN_SEL), 32'h7);
    bus(1'b1, 32'(OFF_LAMP_EN), 32'h7);
    for (int c = 0; c < 16; c++)
    begin
      ch = $urandom_range(2);
      bus(1'b1, ca(ch, OFF_CUR), 32'(c));
      repeat (3) @(posedge hclk);
      chk(32'(glow_ma[5*ch+:5]), ema(c));
      chk(32'(lit), 32'h7);
    end
    for (int i = 0; i < 5; i++)
    begin
      // Full duty last, so channel zero stays steadily lit in the flash test
      d = (i == 0) ? 0 : (i == 4) ? 31 : $urandom_range(30, 1);
      bus(1'b1, ca(0, OFF_DUTY), 32'(d));
      bus(1'b0, ca(0, OFF_DUTY), 32'h0);
      chk(q, 32'(d));
      repeat (2) @(posedge hclk);
      n = 0;
      repeat (64)
      begin
        @(posedge hclk);
        n += int'(lit[0]);
      end
      chk(32'(n), epwm(d));
    end
    bus(1'b1, 32'(OFF_RAMP), 32'h00000101);
    for (int c = 1; c < 3; c++)
    begin
      bus(1'b1, ca(c, OFF_CUR), 32'h9);
      // Ramps of 18 cycles plus 2 on fit well inside a 64 cycle slot
      bus(1'b1, ca(c, OFF_CFG), 32'h001f0001 | 32'(c - 1) << 8);
      bus(1'b1, ca(c, OFF_SLOTS), 32'h04040404);
      bus(1'b1, ca(c, OFF_PERIOD), 32'h4);
    end
    bus(1'b1, 32'(OFF_LAMP_EN), 32'h67);
    repeat (4) @(posedge hclk);
    p = 8;
    seen = 0;
    lo = 0;
    pm = int'(sink_ma[14:10]);
    fork
      repeat (110)
      begin
        bus(1'b0, 32'(OFF_STATUS), 32'h0);
        s = int'(q[14:12]);
        if (p < 8 && s != p)
          chk(32'(s), (p == 4) ? 32'h0 : 32'(p + 1));
        p = s;
      end
      repeat (440)
      begin
        @(posedge hclk);
        if (sink_en[1] === 1'b1)
          chk(32'(sink_ma[9:5]), 32'h14);
        d = int'(sink_ma[14:10]) - pm;
        chk(32'(d * d <= 4), 32'h1);
        pm = int'(sink_ma[14:10]);
        seen |= int'(sink_ma[14:10] == 5'h0a);
        lo += int'(lit[1]);
        chk(32'(lit[0]), 32'h1);
      end
    join
    chk(32'(seen), 32'h1);
    chk(32'(lo > 0 && lo < 440), 32'h1);
    bus(1'b1, 32'(OFF_LAMP_EN), 32'h61);
    repeat (3) @(posedge hclk);
    chk(32'(sink_en), 32'h1);
    bus(1'b1, 32'(OFF_PIN_SEL), 32'h0);
    repeat (3) @(posedge hclk);
    chk(32'(sink_en), 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
